// ==== rtl/cpu_transfer_bit_flag_ops.v ====
// Purpose: executes the transfer, bit, flag and control instructions
// Assumes: software issues one instruction at a time over Avalon-MM
// Notes: all architectural state is local: registers, data, code, io
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "cpu_ops_map.vh"

module cpu_transfer_bit_flag_ops #(
   parameter DMEM_AW = 10,
   parameter PMEM_AW = 10
) (
   input wire sys_clk,
   input wire rst,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   output reg sleep_req,
   output reg watchdog_restart,
   output reg debug_break
);

   // ****************************************
   // state
   // ****************************************
   reg [7:0] gpr [0:31];
   reg [7:0] dmem [0:(1<<DMEM_AW)-1];
   reg [7:0] pmem [0:(1<<PMEM_AW)-1];
   reg [7:0] io [0:63];
   reg [31:0] instr;
   reg [15:0] operand;
   reg [7:0] flags;
   reg [15:0] sp;
   reg [4:0] gpr_sel;
   reg [15:0] dmem_addr;
   reg [15:0] pmem_addr;
   reg [5:0] io_addr;
   reg busy;
   reg [1:0] cnt;
   reg [1:0] last_cycles;
   reg sleeping;
   reg break_seen;
   reg rd_done;
   reg [31:0] next_readdata;
   reg [1:0] next_cycles;

   wire [5:0] op = instr[`INSTR_OP_MSB:0];
   wire [4:0] rd = instr[`INSTR_RD_LSB+4:`INSTR_RD_LSB];
   wire [4:0] rr = instr[`INSTR_RR_LSB+4:`INSTR_RR_LSB];
   wire [2:0] bsel = instr[`INSTR_BIT_LSB+2:`INSTR_BIT_LSB];
   wire [7:0] d_val = gpr[rd];
   wire [7:0] r_val = gpr[rr];
   wire [15:0] zptr = {gpr[31], gpr[30]};
   wire [15:0] zdec = zptr - 16'h0001;
   wire [15:0] zinc = zptr + 16'h0001;
   // q is six bits wide and always adds upwards
   wire [15:0] zq = zptr + {10'h000, operand[5:0]};
   wire [15:0] sp_inc = sp + 16'h0001;
   wire [5:0] port = operand[5:0];
   wire [7:0] code_byte = pmem[zptr[PMEM_AW-1:0]];
   // the last busy edge is where every instruction takes effect
   wire fire = busy && (cnt == 2'd1);

   // ****************************************
   // register map
   // ****************************************
   // 00 instruction: writing it starts execution, reading returns the last one
   // 04 operand: direct address k, displacement q or port number P
   // 08 status: bit 0 busy, bit 1 sleeping, bit 2 break seen, [9:8] cycle count
   // 0C flags: C Z N V S H T I from bit 0 upwards
   // 10 stack pointer, grows downwards
   // 14 register select, 18 register data
   // 1C data address, 20 data byte at that address
   // 24 code address, 28 code byte at that address
   // 2C io address, 30 io byte at that address
   // anything else reads zero and ignores writes
   // registers narrower than 32 bits read back with zeros above
   // the arrays have no reset, so software loads them before use

   // ****************************************
   // instruction word
   // ****************************************
   // [5:0] opcode, [12:8] destination, [20:16] source, [26:24] bit or flag index
   // the other bits are ignored, so software may leave them at zero
   // the opcode field is six bits, so 64 codes fit and 28 are used
   // Z is the pair R31:R30, high byte in R31

   // ****************************************
   // timing
   // ****************************************
   // a read stalls one cycle while readdata is captured, then answers
   // one edge of latency keeps readdata a flip-flop output
   // an instruction write is taken at once and raises busy for 1, 2 or 3 cycles
   // the effects land on the last busy edge; the next write waits until busy drops
   // back-to-back writes are fine; the stall comes from busy alone
   // reads never wait on busy, so software can poll the status word

   // ****************************************
   // avalon slave handshake
   // ****************************************
   // writes stall while busy so software never races the executing instruction
   wire wr_ok = write && !busy;
   assign waitrequest = (read && !rd_done) || (write && busy);
   wire wr_take = wr_ok && !read;
   wire start = wr_take && (address == `OFF_INSTR);

   // ****************************************
   // opcode groups and cycle counts
   // ****************************************
   // stores through Z, Z+, -Z, Z+q and direct address: 2 cycles
   // push, pop, io bit set and io bit clear: 2 cycles
   // code memory reads into R0 or Rd, with or without Z+1: 3 cycles
   // shifts, rotates, swap, flag ops, T transfers, in, out: 1 cycle
   // nop, sleep, watchdog restart and break: 1 cycle
   // undefined opcodes run for 1 cycle and change nothing
   // [RULE21] local opcode decode
   always @* begin
      case (writedata[`INSTR_OP_MSB:0])
         // indirect stores
         `OP_ST_Z, `OP_ST_ZINC, `OP_ST_ZDEC, `OP_ST_ZQ: begin
            next_cycles = `CYC_MEM;
         end
         // direct store
         `OP_ST_DIR: begin
            next_cycles = `CYC_MEM;
         end
         // stack
         `OP_PUSH, `OP_POP: begin
            next_cycles = `CYC_MEM;
         end
         // io bit ops
         `OP_IO_SET, `OP_IO_CLR: begin
            next_cycles = `CYC_MEM;
         end
         // code memory reads
         `OP_LPM_R0, `OP_LPM, `OP_LPM_INC: begin
            next_cycles = `CYC_CODE;
         end
         // everything else is one cycle
         default: begin
            next_cycles = `CYC_ONE;
         end
      endcase
   end

   always @* begin
      case (address)
         `OFF_INSTR: next_readdata = instr;
         `OFF_OPERAND: next_readdata = {16'h0000, operand};
         // busy, sleeping, break seen and the cycle count of the last instruction
         `OFF_STATUS: next_readdata = {22'h000000, last_cycles, 5'h00, break_seen,
            sleeping, busy};
         `OFF_FLAGS: next_readdata = {24'h000000, flags};
         `OFF_SP: next_readdata = {16'h0000, sp};
         `OFF_GPR_SEL: next_readdata = {27'h0000000, gpr_sel};
         `OFF_GPR_DATA: next_readdata = {24'h000000, gpr[gpr_sel]};
         `OFF_DMEM_ADDR: next_readdata = {16'h0000, dmem_addr};
         `OFF_DMEM_DATA: next_readdata = {24'h000000, dmem[dmem_addr[DMEM_AW-1:0]]};
         `OFF_PMEM_ADDR: next_readdata = {16'h0000, pmem_addr};
         `OFF_PMEM_DATA: next_readdata = {24'h000000, pmem[pmem_addr[PMEM_AW-1:0]]};
         `OFF_IO_ADDR: next_readdata = {26'h0000000, io_addr};
         `OFF_IO_DATA: next_readdata = {24'h000000, io[io_addr]};
         default: next_readdata = 32'h00000000;
      endcase
   end

   // ****************************************
   // shift and rotate unit
   // ****************************************
   reg [7:0] sh_res;
   reg sh_c;
   always @* begin
      sh_res = d_val;
      sh_c = flags[`FLAG_C];
      case (op)
         // [RULE9] zero into bit 0
         `OP_LSL: begin
            sh_res = {d_val[6:0], 1'b0};
            sh_c = d_val[7];
         end
         // [RULE10] zero into bit 7
         `OP_LSR: begin
            sh_res = {1'b0, d_val[7:1]};
            sh_c = d_val[0];
         end
         // [RULE11] carry into bit 0
         `OP_ROL: begin
            sh_res = {d_val[6:0], flags[`FLAG_C]};
            sh_c = d_val[7];
         end
         // [RULE12] carry into bit 7
         `OP_ROR: begin
            sh_res = {flags[`FLAG_C], d_val[7:1]};
            sh_c = d_val[0];
         end
         // [RULE13] sign bit kept
         `OP_ASR: begin
            sh_res = {d_val[7], d_val[7:1]};
            sh_c = d_val[0];
         end
         default: begin
            sh_res = d_val;
            sh_c = flags[`FLAG_C];
         end
      endcase
   end
   // S is left alone by the shifts; only Z, C, N and V follow the result
   wire sh_op = (op == `OP_LSL) || (op == `OP_LSR) || (op == `OP_ROL) ||
      (op == `OP_ROR) || (op == `OP_ASR);

   // ****************************************
   // control registers and flags
   // ****************************************
   // reset leaves flags clear and the stack pointer at the top of data memory
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         instr <= 32'h00000000;
         operand <= 16'h0000;
         flags <= `FLAGS_RESET;
         sp <= `SP_RESET;
         gpr_sel <= 5'h00;
         dmem_addr <= 16'h0000;
         pmem_addr <= 16'h0000;
         io_addr <= 6'h00;
         busy <= 1'b0;
         cnt <= 2'd0;
         last_cycles <= 2'd0;
         sleeping <= 1'b0;
         break_seen <= 1'b0;
         rd_done <= 1'b0;
         readdata <= 32'h00000000;
         sleep_req <= 1'b0;
         watchdog_restart <= 1'b0;
         debug_break <= 1'b0;
      end else begin
         rd_done <= read && !rd_done;
         // capture on the first edge of a read; the answer stands from the next
         if (read && !rd_done) begin
            readdata <= next_readdata;
         end
         // control strobes last one cycle unless an instruction fires below
         sleep_req <= 1'b0;
         watchdog_restart <= 1'b0;
         debug_break <= 1'b0;
         if (wr_take) begin
            case (address)
               `OFF_OPERAND: operand <= writedata[15:0];
               `OFF_FLAGS: flags <= writedata[7:0];
               `OFF_SP: sp <= writedata[15:0];
               `OFF_GPR_SEL: gpr_sel <= writedata[4:0];
               `OFF_DMEM_ADDR: dmem_addr <= writedata[15:0];
               `OFF_PMEM_ADDR: pmem_addr <= writedata[15:0];
               `OFF_IO_ADDR: io_addr <= writedata[5:0];
               default: begin
               end
            endcase
         end
         if (start) begin
            instr <= writedata;
            busy <= 1'b1;
            cnt <= next_cycles;
            last_cycles <= next_cycles;
            sleeping <= 1'b0;
            break_seen <= 1'b0;
         end else if (busy) begin
            cnt <= cnt - 2'd1;
         end
         if (fire) begin
            busy <= 1'b0;
            case (op)
               // [RULE5] push, post-decrement
               `OP_PUSH: sp <= sp - 16'h0001;
               // [RULE6] pop, pre-increment
               `OP_POP: sp <= sp_inc;
               // [RULE14] only T changes
               `OP_TBIT_FROM: flags[`FLAG_T] <= r_val[bsel];
               // [RULE16] [RULE17] [RULE18] single flag set
               `OP_FLAG_SET: flags[bsel] <= 1'b1;
               // [RULE16] [RULE17] [RULE18] single flag clear
               `OP_FLAG_CLR: flags[bsel] <= 1'b0;
               // [RULE19] hand over to sleep logic
               `OP_SLEEP: begin
                  sleep_req <= 1'b1;
                  sleeping <= 1'b1;
               end
               // [RULE19] watchdog restart strobe
               `OP_WDR: watchdog_restart <= 1'b1;
               // [RULE20] debug strobe and break seen status bit only
               `OP_BREAK: begin
                  debug_break <= 1'b1;
                  break_seen <= 1'b1;
               end
               default: begin
               end
            endcase
            // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] flag update
            if (sh_op) begin
               flags[`FLAG_C] <= sh_c;
               flags[`FLAG_Z] <= (sh_res == 8'h00);
               flags[`FLAG_N] <= sh_res[7];
               flags[`FLAG_V] <= sh_res[7] ^ sh_c;
            end
         end
      end
   end

   // ****************************************
   // storage writes
   // ****************************************
   // one process owns all arrays; software writes are blocked while busy
   // the io bit ops read and write the same port in one edge, so no other
   // write to that port can slip in between
   always @(posedge sys_clk) begin
      if (wr_take) begin
         case (address)
            `OFF_GPR_DATA: gpr[gpr_sel] <= writedata[7:0];
            `OFF_DMEM_DATA: dmem[dmem_addr[DMEM_AW-1:0]] <= writedata[7:0];
            `OFF_PMEM_DATA: pmem[pmem_addr[PMEM_AW-1:0]] <= writedata[7:0];
            `OFF_IO_DATA: io[io_addr] <= writedata[7:0];
            default: begin
            end
         endcase
      end
      if (fire) begin
         case (op)
            `OP_ST_Z: dmem[zptr[DMEM_AW-1:0]] <= r_val;
            `OP_ST_ZINC: begin
               dmem[zptr[DMEM_AW-1:0]] <= r_val;
               gpr[30] <= zinc[7:0];
               gpr[31] <= zinc[15:8];
            end
            // [RULE1] decrement then store
            `OP_ST_ZDEC: begin
               dmem[zdec[DMEM_AW-1:0]] <= r_val;
               gpr[30] <= zdec[7:0];
               gpr[31] <= zdec[15:8];
            end
            // [RULE2] displaced store
            `OP_ST_ZQ: dmem[zq[DMEM_AW-1:0]] <= r_val;
            // [RULE3] direct store
            `OP_ST_DIR: dmem[operand[DMEM_AW-1:0]] <= r_val;
            // [RULE4] code read into R0
            `OP_LPM_R0: gpr[0] <= code_byte;
            // [RULE4] code read into Rd
            `OP_LPM: gpr[rd] <= code_byte;
            // [RULE4] code read, Z advances
            `OP_LPM_INC: begin
               gpr[rd] <= code_byte;
               gpr[30] <= zinc[7:0];
               gpr[31] <= zinc[15:8];
            end
            `OP_IN: gpr[rd] <= io[port];
            `OP_OUT: io[port] <= r_val;
            // [RULE5] stack write
            `OP_PUSH: dmem[sp[DMEM_AW-1:0]] <= r_val;
            // [RULE6] stack read
            `OP_POP: gpr[rd] <= dmem[sp_inc[DMEM_AW-1:0]];
            // [RULE7] one bit high
            `OP_IO_SET: io[port] <= io[port] | (8'h01 << bsel);
            // [RULE8] one bit low
            `OP_IO_CLR: io[port] <= io[port] & ~(8'h01 << bsel);
            `OP_LSL, `OP_LSR, `OP_ROL, `OP_ROR, `OP_ASR: gpr[rd] <= sh_res;
            `OP_SWAP: gpr[rd] <= {d_val[3:0], d_val[7:4]};
            // [RULE15] T into bit b
            `OP_TBIT_TO: gpr[rd][bsel] <= flags[`FLAG_T];
            default: begin
            end
         endcase
      end
   end

endmodule // cpu_transfer_bit_flag_ops

// ==== rtl/cpu_ops_map.vh ====
// Purpose: constants for the transfer, bit and control execution unit
// Assumes: byte offsets on a 32-bit Avalon-MM slave, word aligned
// Notes: opcode codes are local to this unit, not the full instruction set
// Function
// [RULE1] store via -Z: decrement Z, write at new Z, 2 cycles, no flags
// [RULE2] store via Z+q: write at Z plus q, Z kept, no flags, 2 cycles
// [RULE3] direct store writes source at address k, no flags, 2 cycles
// [RULE4] code read loads byte at Z into Rd or R0, optional Z+1, 3 cycles
// [RULE5] push writes source onto stack in 2 cycles, flags kept
// [RULE6] pop reads top stack byte into destination in 2 cycles, flags kept
// [RULE7] io bit set forces bit b of port P high, 2 cycles, flags kept
// [RULE8] io bit clear forces bit b of port P low, 2 cycles, flags kept
// [RULE9] left shift, zero into bit 0, updates Z C N V, one cycle
// [RULE10] right shift, zero into bit 7, updates Z C N V, one cycle
// [RULE11] rotate left through carry, updates Z C N V, one cycle
// [RULE12] rotate right through carry, updates Z C N V, one cycle
// [RULE13] arithmetic right shift keeps bit 7, updates Z C N V, one cycle
// [RULE14] copy register bit b into T, only T changes, one cycle
// [RULE15] copy T into register bit b, flags kept, one cycle
// [RULE16] overflow flag set or clear in one cycle, nothing else changes
// [RULE17] half carry set or clear in one cycle, nothing else changes
// [RULE18] sign flag set or clear in one cycle, nothing else changes
// [RULE19] sleep, watchdog restart and no-op take one cycle, flags kept
// [RULE20] break only signals debug, flags kept, no normal cycle count; this unit runs break for 1 cycle
// [RULE21] opcode encoding is chosen locally below
`ifndef CPU_OPS_MAP_VH
`define CPU_OPS_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_INSTR 6'h00
`define OFF_OPERAND 6'h04
`define OFF_STATUS 6'h08
`define OFF_FLAGS 6'h0C
`define OFF_SP 6'h10
`define OFF_GPR_SEL 6'h14
`define OFF_GPR_DATA 6'h18
`define OFF_DMEM_ADDR 6'h1C
`define OFF_DMEM_DATA 6'h20
`define OFF_PMEM_ADDR 6'h24
`define OFF_PMEM_DATA 6'h28
`define OFF_IO_ADDR 6'h2C
`define OFF_IO_DATA 6'h30

// ****************************************
// instruction word fields and reset values
// ****************************************
`define INSTR_OP_MSB 5
`define INSTR_RD_LSB 8
`define INSTR_RR_LSB 16
`define INSTR_BIT_LSB 24
`define SP_RESET 16'h03FF
`define FLAGS_RESET 8'h00

// ****************************************
// flag register bit positions
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ****************************************
// opcodes and cycle counts
// ****************************************
`define OP_NOP 6'h00
`define OP_SLEEP 6'h01
`define OP_WDR 6'h02
`define OP_BREAK 6'h03
`define OP_ST_Z 6'h04
`define OP_ST_ZINC 6'h05
`define OP_ST_ZDEC 6'h06
`define OP_ST_ZQ 6'h07
`define OP_ST_DIR 6'h08
`define OP_LPM_R0 6'h09
`define OP_LPM 6'h0A
`define OP_LPM_INC 6'h0B
`define OP_IN 6'h0C
`define OP_OUT 6'h0D
`define OP_PUSH 6'h0E
`define OP_POP 6'h0F
`define OP_IO_SET 6'h10
`define OP_IO_CLR 6'h11
`define OP_LSL 6'h12
`define OP_LSR 6'h13
`define OP_ROL 6'h14
`define OP_ROR 6'h15
`define OP_ASR 6'h16
`define OP_SWAP 6'h17
`define OP_FLAG_SET 6'h18
`define OP_FLAG_CLR 6'h19
`define OP_TBIT_FROM 6'h1A
`define OP_TBIT_TO 6'h1B
`define CYC_ONE 2'd1
`define CYC_MEM 2'd2
`define CYC_CODE 2'd3

`endif

// ==== bench/ops_checker.sv ====
// Purpose: bus timing, cycle count and pulse checks for the execution unit
// Assumes: sees only the unit's ports; the host idles one cycle between requests
// Notes: cycle counts show up as stalls of the write that follows an instruction
`timescale 1ns/1ps
`include "cpu_ops_map.vh"
module ops_checker (
   input wire sys_clk,
   input wire rst,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire sleep_req,
   input wire watchdog_restart,
   input wire debug_break
);
   // ****************************************
   // issue decode
   // ****************************************
   wire go = write && !waitrequest && address == `OFF_INSTR;
   wire [5:0] op = writedata[5:0];
   // a write that is absent cannot show a stall, so it passes either way
   wire hold = !write || waitrequest;
   wire free = !write || !waitrequest;
   wire pulse = sleep_req || watchdog_restart || debug_break;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_one_cycle: assert property (
      go && op inside {[`OP_LSL:`OP_TBIT_TO], [`OP_NOP:`OP_WDR]} |=> hold ##1 free)
      else $error("one cycle instruction has wrong length");
   a_mem_cycle: assert property (
      go && op inside {[`OP_ST_Z:`OP_ST_DIR], [`OP_PUSH:`OP_IO_CLR]} |=> hold [*2] ##1 free)
      else $error("two cycle instruction has wrong length");
   a_code_cycle: assert property (
      go && op inside {[`OP_LPM_R0:`OP_LPM_INC]} |=> hold [*3] ##1 free)
      else $error("code read has wrong length");
   a_sleep_pulse: assert property (go && op == `OP_SLEEP |-> ##[1:3] sleep_req)
      else $error("sleep pulse missing");
   a_wdr_pulse: assert property (go && op == `OP_WDR |-> ##[1:3] watchdog_restart)
      else $error("watchdog pulse missing");
   a_break_pulse: assert property (go && op == `OP_BREAK |-> ##[1:3] debug_break)
      else $error("break pulse missing");
   a_pulse_short: assert property (pulse |=> !pulse)
      else $error("control pulse longer than one cycle");
   a_read_answer: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read answer not one cycle late");
   a_unmapped_zero: assert property (
      read && !waitrequest && address == 6'h3C |-> readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // ops_checker

// ==== bench/host_bus.sv ====
// Purpose: register bus master standing in for software
// Assumes: requests start right after a rising edge
// Notes: one idle cycle after each transfer keeps each signal to one assignment a step
`timescale 1ns/1ps
module host_bus (
   input wire sys_clk,
   input wire [31:0] readdata,
   input wire waitrequest,
   output logic [5:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata
);
   // ****************************************
   // transfers
   // ****************************************
   initial begin
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   task wr(input logic [5:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      @(posedge sys_clk);
      while (waitrequest) @(posedge sys_clk);
      write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [5:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      @(posedge sys_clk);
      while (waitrequest) @(posedge sys_clk);
      d = readdata;
      read <= 1'b0;
      @(posedge sys_clk);
   endtask
endmodule // host_bus

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the execution unit
// Assumes: host_bus drives the register bus
// Notes: table rows cover the one-cycle shift, T, flag and control instructions
`timescale 1ns/1ps
`include "cpu_ops_map.vh"
module tb_top;
   logic sys_clk;
   logic rst;
   wire [5:0] address;
   wire read;
   wire write;
   wire [31:0] writedata;
   wire [31:0] readdata;
   wire waitrequest;
   wire sleep_req;
   wire watchdog_restart;
   wire debug_break;
   int miscompares = 0;
   int checks = 0;
   // row: op, bit, reg in, flags in, reg out, flags out
   logic [47:0] rows [20];
   host_bus bus (.sys_clk(sys_clk), .readdata(readdata), .waitrequest(waitrequest),
      .address(address), .read(read), .write(write), .writedata(writedata));
   cpu_transfer_bit_flag_ops #(.DMEM_AW(10), .PMEM_AW(10)) uut (.sys_clk(sys_clk),
      .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .sleep_req(sleep_req),
      .watchdog_restart(watchdog_restart), .debug_break(debug_break));
   // ****************************************
   // helpers
   // ****************************************
   task summarize();
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task ck(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus.rd(a, d);
      checks++;
      if (d !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, d, e);
      end
   endtask
   task put(input logic [5:0] ra, input logic [31:0] a, input logic [5:0] rb,
      input logic [31:0] v);
      bus.wr(ra, a);
      bus.wr(rb, v);
   endtask
   task look(input logic [5:0] ra, input logic [31:0] a, input logic [5:0] rb,
      input logic [31:0] v);
      bus.wr(ra, a);
      ck(rb, v);
   endtask
   // the select write stalls until the instruction is done
   task ex(input logic [5:0] op, input logic [4:0] d, input logic [4:0] s,
      input logic [2:0] b);
      bus.wr(`OFF_INSTR, {5'h0, b, 3'h0, s, 3'h0, d, 2'h0, op});
      bus.wr(`OFF_GPR_SEL, {27'h0, d});
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      summarize();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      rows = '{48'h120081000209, 48'h12008000000B, 48'h13000170007B, 48'h140080010109,
         48'h150001018005, 48'h16008200C10C, 48'h1A0308000840, 48'h1A03F7FFF7BF,
         48'h1B0600404040, 48'h1B00FFBFFEBF, 48'h180300000008, 48'h190300FF00F7,
         48'h180500000020, 48'h190500FF00DF, 48'h180400000010, 48'h190400FF00EF,
         48'h00005AA55AA5, 48'h01005AA55AA5, 48'h02005AA55AA5, 48'h03005AA55AA5};
      rst = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 20; i++) begin
         put(`OFF_GPR_SEL, 32'd5, `OFF_GPR_DATA, {24'h0, rows[i][31:24]});
         bus.wr(`OFF_FLAGS, {24'h0, rows[i][23:16]});
         ex(rows[i][45:40], 5'd5, 5'd5, rows[i][34:32]);
         ck(`OFF_GPR_DATA, {24'h0, rows[i][15:8]});
         ck(`OFF_FLAGS, {24'h0, rows[i][7:0]});
      end
      ck(`OFF_STATUS, 32'h104);
      bus.wr(`OFF_FLAGS, 32'h55);
      put(`OFF_GPR_SEL, 32'd30, `OFF_GPR_DATA, 32'h10);
      put(`OFF_GPR_SEL, 32'd31, `OFF_GPR_DATA, 32'h00);
      put(`OFF_GPR_SEL, 32'd7, `OFF_GPR_DATA, 32'hA5);
      put(`OFF_DMEM_ADDR, 32'h10, `OFF_DMEM_DATA, 32'h00);
      ex(`OP_ST_ZDEC, 5'd0, 5'd7, 3'd0);
      look(`OFF_DMEM_ADDR, 32'h0F, `OFF_DMEM_DATA, 32'hA5);
      look(`OFF_DMEM_ADDR, 32'h10, `OFF_DMEM_DATA, 32'h00);
      look(`OFF_GPR_SEL, 32'd30, `OFF_GPR_DATA, 32'h0F);
      bus.wr(`OFF_OPERAND, 32'h05);
      ex(`OP_ST_ZQ, 5'd0, 5'd7, 3'd0);
      bus.wr(`OFF_OPERAND, 32'h0123);
      ex(`OP_ST_DIR, 5'd0, 5'd7, 3'd0);
      look(`OFF_DMEM_ADDR, 32'h14, `OFF_DMEM_DATA, 32'hA5);
      look(`OFF_DMEM_ADDR, 32'h123, `OFF_DMEM_DATA, 32'hA5);
      look(`OFF_GPR_SEL, 32'd30, `OFF_GPR_DATA, 32'h0F);
      put(`OFF_PMEM_ADDR, 32'h0F, `OFF_PMEM_DATA, 32'h99);
      put(`OFF_PMEM_ADDR, 32'h10, `OFF_PMEM_DATA, 32'h66);
      ex(`OP_LPM_INC, 5'd9, 5'd0, 3'd0);
      ck(`OFF_GPR_DATA, 32'h99);
      ck(`OFF_STATUS, 32'h300);
      ex(`OP_LPM_R0, 5'd3, 5'd0, 3'd0);
      look(`OFF_GPR_SEL, 32'd0, `OFF_GPR_DATA, 32'h66);
      look(`OFF_GPR_SEL, 32'd30, `OFF_GPR_DATA, 32'h10);
      ex(`OP_PUSH, 5'd0, 5'd7, 3'd0);
      look(`OFF_DMEM_ADDR, 32'h3FF, `OFF_DMEM_DATA, 32'hA5);
      ck(`OFF_SP, 32'h3FE);
      ex(`OP_POP, 5'd11, 5'd0, 3'd0);
      ck(`OFF_GPR_DATA, 32'hA5);
      ck(`OFF_SP, 32'h3FF);
      bus.wr(`OFF_OPERAND, 32'h3F);
      put(`OFF_IO_ADDR, 32'h3F, `OFF_IO_DATA, 32'h00);
      ex(`OP_IO_SET, 5'd0, 5'd0, 3'd7);
      ck(`OFF_IO_DATA, 32'h80);
      bus.wr(`OFF_IO_DATA, 32'hFF);
      ex(`OP_IO_CLR, 5'd0, 5'd0, 3'd7);
      ck(`OFF_IO_DATA, 32'h7F);
      ck(`OFF_FLAGS, 32'h55);
      ck(6'h3C, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      ck(`OFF_FLAGS, {24'h0, `FLAGS_RESET});
      ck(`OFF_SP, {16'h0, `SP_RESET});
      summarize();
   end
endmodule // tb_top
bind cpu_transfer_bit_flag_ops ops_checker chk (.sys_clk(sys_clk), .rst(rst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .sleep_req(sleep_req),
   .watchdog_restart(watchdog_restart), .debug_break(debug_break));
